// ==== lidf_pkg.sv ====
// lidf_pkg: constants and types for the lossless image decode front end.
// assumes a single 20 MHz graphics-engine clock and an Avalon-MM register port.
package lidf_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [5:0] LIDF_OFS_CTRL = 6'h00;
  localparam logic [5:0] LIDF_OFS_STATUS = 6'h04;
  localparam logic [5:0] LIDF_OFS_POS = 6'h08;
  localparam logic [5:0] LIDF_OFS_SIZE = 6'h0c;
  localparam logic [5:0] LIDF_OFS_RES = 6'h10;
  localparam logic [5:0] LIDF_OFS_BASE = 6'h14;
  localparam logic [5:0] LIDF_OFS_REMAIN = 6'h18;
  localparam int LIDF_CTRL_EN_BIT = 0;
  localparam logic LIDF_CTRL_EN_RST = 1'b1;
  localparam logic [1:0] LIDF_RESP_OK = 2'h0;
  localparam logic [1:0] LIDF_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // command word layout
  // ----------------------------------------------------------------
  localparam int LIDF_HDR_WORDS = 6;
  localparam int LIDF_LO_LSB = 0;
  localparam int LIDF_HI_LSB = 16;
  localparam int LIDF_FIELD_W = 12;
  localparam int LIDF_BASE_LSB = 7;
  localparam int LIDF_MODE_LSB = 14;
  localparam logic [31:0] LIDF_FIX_LEN = 32'h10;
  localparam logic [11:0] LIDF_MAX_W = 12'h800;
  localparam logic [1:0] LIDF_MODE_RSVD = 2'h0;
  localparam logic [1:0] LIDF_MODE_16 = 2'h1;
  localparam logic [1:0] LIDF_MODE_24 = 2'h2;
  localparam logic [1:0] LIDF_MODE_16UP = 2'h3;

  // ----------------------------------------------------------------
  // image stream
  // ----------------------------------------------------------------
  localparam logic [5:0] LIDF_IMG_HDR_LEN = 6'h23;
  localparam logic [7:0] LIDF_MK_PREFIX = 8'hff;
  localparam logic [7:0] LIDF_MK_EOI = 8'hd9;
  localparam logic [7:0] LIDF_THR1 = 8'h03;
  localparam logic [7:0] LIDF_THR2 = 8'h07;
  localparam logic [7:0] LIDF_THR3 = 8'h15;
  localparam logic [7:0] LIDF_RESET_VAL = 8'h40;

  // ----------------------------------------------------------------
  // error codes
  // ----------------------------------------------------------------
  localparam logic [3:0] LIDF_ERR_NONE = 4'h0;
  localparam logic [3:0] LIDF_ERR_LEN = 4'h1;
  localparam logic [3:0] LIDF_ERR_SHORT = 4'h2;
  localparam logic [3:0] LIDF_ERR_LONG = 4'h3;
  localparam logic [3:0] LIDF_ERR_MODE = 4'h4;
  localparam logic [3:0] LIDF_ERR_SIZE = 4'h5;
  localparam logic [3:0] LIDF_ERR_BOUNDS = 4'h6;
  localparam logic [3:0] LIDF_ERR_EOI = 4'h7;
  localparam logic [3:0] LIDF_ERR_HDR = 4'h8;
  localparam logic [3:0] LIDF_ERR_DPATH = 4'h9;

  typedef enum logic [2:0] {
    LIDF_IDLE, LIDF_CMD, LIDF_IMG, LIDF_DATA, LIDF_TAIL, LIDF_DONE, LIDF_FAIL
  } lidf_state_t;

endpackage

// ==== lidf_src_model.sv ====
// lidf_src_model: command word source standing in front of the decode front.
// assumes one clock; words come from the bench's table, one per handshake.
module lidf_src_model (
  // clock, reset, restart
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  // word table and limits
  input wire logic [31:0] mem_i [32],
  input wire logic [5:0] n_i,
  input wire logic [5:0] hold_i,
  // word handshake
  input wire logic ready_i,
  output logic [31:0] data_o,
  output logic valid_o
);
  logic [5:0] ptr_reg;
  logic [31:0] last_reg;
  // stall at hold_i lets the bench pace the tail of the stream
  assign valid_o = (ptr_reg < n_i) && (ptr_reg != hold_i);
  // released bus shows no stale word
  assign data_o = valid_o ? mem_i[ptr_reg] : ~last_reg;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ptr_reg <= 6'h00;
      last_reg <= 32'h0;
    end else if (start_i) begin
      ptr_reg <= 6'h00;
    end else if (valid_o && ready_i) begin
      ptr_reg <= ptr_reg + 6'h01;
      last_reg <= mem_i[ptr_reg];
    end
  end
endmodule // lidf_src_model

// ==== lidf_top.sv ====
// lidf_top: command reader, header processor and byte feeder of the decoder.
// assumes the decoder, command parser and word source all run on clk_i.
// How it works
// [RL1] mode bits 15:14: 11 up-converting 16bpp, 10 24bpp, 01 16bpp, 00 rejected.
// [RL2] 16bpp modes keep top 5 red, 6 green, 5 blue bits.
// [RL3] frame base in bits 31:7, 128-byte units; bits 6:0 ignored.
// [RL4] x, width, horizontal resolution are 12-bit fields in bits 11:0; y, height, vertical resolution in bits 27:16.
// [RL5] issuer keeps horizontal resolution a multiple of 8 for 24bpp and up-converting.
// [RL6] length below 16 plus one image byte gives code 1.
// [RL7] rectangle outside frame resolution gives code 6.
// [RL8] zero height or width, or width above 2048, gives code 5.
// [RL9] unsupported color mode gives code 4.
// [RL10] markers must run soi, sof, sos, data, eoi; bad parameters give code 8.
// [RL11] frame lines or samples differing from command height or width give code 8.
// [RL12] lse, dnl, dri, rst, app and com markers are refused as unsupported.
// [RL13] never read past length; running dry before last pixel gives code 2.
// [RL14] residual length or prefetched data after last pixel gives code 3.
// [RL15] missing or misplaced end-of-image marker gives code 7.
// [RL16] any error aborts, reports to parser, then idles until deselected.
// [RL17] deselect before completion abandons the command and returns to idle.
// [RL18] each source word is consumed lowest byte first.
// [RL19] compressed samples are 24-bit in every mode.
// [RL20] zero to three pad bytes after the end marker are discarded.
// [RL21] regular and run modes decoded downstream at about 3 and 1 clocks per pixel.
// [RL22] frame header: length 0x0011, precision 8, components 1..3, factors 1, table 0.
// [RL23] scan header: length 0x000c, three components, near 0, ilv 2, approx 0.
// [RL24] fixed thresholds 3, 7, 21 and reset 64 go to the decoder.
// [RL25] only the first error code is kept until deselected.
// [RL26] completion is raised after an error-free last pixel and held until deselect.
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
module lidf_top
  import lidf_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // avalon-mm register slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic [1:0] avs_response_o,
  output logic avs_waitrequest_o,
  // command parser
  input wire logic sel_i,
  output logic done_o,
  output logic err_o,
  output logic [3:0] err_code_o,
  // command data source
  input wire logic [31:0] src_data_i,
  input wire logic src_valid_i,
  output logic src_ready_o,
  // data segment decoder
  output logic [7:0] dec_byte_o,
  output logic dec_byte_valid_o,
  input wire logic dec_byte_ready_i,
  input wire logic dec_pix_valid_i,
  input wire logic [23:0] dec_pix_i,
  input wire logic dec_pix_last_i,
  input wire logic dec_residue_i,
  input wire logic dec_err_i,
  output logic [11:0] img_width_o,
  output logic [11:0] img_height_o,
  output logic [7:0] thr1_o,
  output logic [7:0] thr2_o,
  output logic [7:0] thr3_o,
  output logic [7:0] reset_val_o,
  // pixel writer
  output logic [23:0] pix_o,
  output logic pix_valid_o,
  output logic [1:0] mode_o,
  output logic [11:0] hres_o,
  output logic [31:0] base_addr_o
);
  import lidf_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    lidf_state_t st;
    logic [2:0] widx;
    logic [31:0] len;
    logic [31:0] rem;
    logic [11:0] x, y, w, h, hr, vr;
    logic [1:0] mode;
    logic [24:0] base;
    logic [31:0] wbuf;
    logic [2:0] wcnt;
    logic [5:0] hidx;
    logic ff_pend;
    logic ff_fwd;
    logic [3:0] err;
    logic en;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic [23:0] pix;
    logic pix_v;
  } lidf_regs_t;

  lidf_regs_t r_reg, r_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // expected image header byte; the size fields come from the command
  function automatic logic [7:0] lidf_hdr_byte(input logic [5:0] i, input logic [11:0] h,
                                               input logic [11:0] w);
    case (i)
      6'd0, 6'd2, 6'd21: lidf_hdr_byte = LIDF_MK_PREFIX; // RL10
      6'd1: lidf_hdr_byte = 8'hd8;
      6'd3: lidf_hdr_byte = 8'hf7;
      6'd5: lidf_hdr_byte = 8'h11; // RL22
      6'd6: lidf_hdr_byte = 8'h08; // RL22
      6'd7: lidf_hdr_byte = {4'h0, h[11:8]}; // RL11
      6'd8: lidf_hdr_byte = h[7:0]; // RL11
      6'd9: lidf_hdr_byte = {4'h0, w[11:8]}; // RL11
      6'd10: lidf_hdr_byte = w[7:0]; // RL11
      6'd11, 6'd18, 6'd25, 6'd30: lidf_hdr_byte = 8'h03;
      6'd12, 6'd26: lidf_hdr_byte = 8'h01;
      6'd13, 6'd16, 6'd19: lidf_hdr_byte = 8'h11; // RL22
      6'd15, 6'd28, 6'd33: lidf_hdr_byte = 8'h02; // RL22 RL23
      6'd22: lidf_hdr_byte = 8'hda;
      6'd24: lidf_hdr_byte = 8'h0c; // RL23
      default: lidf_hdr_byte = 8'h00;
    endcase
  endfunction

  // markers the stream may not carry
  function automatic logic lidf_unsup(input logic [7:0] b);
    lidf_unsup = (b == 8'hf8) || (b == 8'hdc) || (b == 8'hdd) || (b[7:3] == 5'h1a) ||
                 (b[7:4] == 4'he) || (b == 8'hfe); // RL12
  endfunction

  logic [7:0] cur_b;
  logic avail;
  logic dry;
  logic busy;
  logic [12:0] xw, yh;

  assign cur_b = r_reg.wbuf[7:0]; // RL18
  assign avail = (r_reg.wcnt != 3'h0);
  assign dry = !avail && (r_reg.rem == 32'h0);
  assign busy = (r_reg.st != LIDF_IDLE) && (r_reg.st != LIDF_DONE) && (r_reg.st != LIDF_FAIL);
  assign xw = {1'b0, r_reg.x} + {1'b0, r_reg.w};
  assign yh = {1'b0, r_reg.y} + {1'b0, r_reg.h};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] e;
    logic consume;
    logic [31:0] d;
    r_next = r_reg;
    e = LIDF_ERR_NONE;
    consume = 1'b0;
    d = src_data_i;
    r_next.pix_v = 1'b0;

    // register bus: one wait state, read data captured on the first cycle
    r_next.ack = (avs_read_i || avs_write_i) && !r_reg.ack;
    if ((avs_read_i || avs_write_i) && !r_reg.ack) begin
      r_next.resp = LIDF_RESP_OK;
      r_next.rdata = 32'h0;
      case (avs_address_i)
        LIDF_OFS_CTRL: r_next.rdata = {31'h0, r_reg.en};
        LIDF_OFS_STATUS: r_next.rdata = {16'h0, 5'h0, r_reg.st, r_reg.err, 2'h0,
                                         r_reg.st == LIDF_FAIL, r_reg.st == LIDF_DONE};
        LIDF_OFS_POS: r_next.rdata = {4'h0, r_reg.y, 4'h0, r_reg.x};
        LIDF_OFS_SIZE: r_next.rdata = {4'h0, r_reg.h, 4'h0, r_reg.w};
        LIDF_OFS_RES: r_next.rdata = {4'h0, r_reg.vr, r_reg.mode, 2'h0, r_reg.hr};
        LIDF_OFS_BASE: r_next.rdata = {r_reg.base, 7'h0};
        LIDF_OFS_REMAIN: r_next.rdata = r_reg.rem;
        default: r_next.resp = LIDF_RESP_SLVERR;
      endcase
      if (avs_write_i && avs_address_i == LIDF_OFS_CTRL && avs_byteenable_i[0]) begin
        r_next.en = avs_writedata_i[LIDF_CTRL_EN_BIT];
      end
    end

    // word refill for the byte states
    if (src_valid_i && src_ready_o && r_reg.st != LIDF_CMD) begin
      r_next.wbuf = d;
      r_next.wcnt = 3'h4;
    end

    case (r_reg.st)
      LIDF_IDLE: begin
        if (sel_i && r_reg.en) begin
          r_next.st = LIDF_CMD;
          r_next.widx = 3'h0;
          r_next.err = LIDF_ERR_NONE;
          r_next.wcnt = 3'h0;
          r_next.rem = 32'h0;
          r_next.ff_pend = 1'b0;
          r_next.ff_fwd = 1'b0;
        end
      end
      LIDF_CMD: begin
        if (src_valid_i) begin
          r_next.widx = r_reg.widx + 3'h1;
          case (r_reg.widx)
            3'h1: begin
              r_next.len = d;
              if (d < LIDF_FIX_LEN + 32'h1) e = LIDF_ERR_LEN; // RL6
            end
            3'h2: begin
              r_next.x = d[LIDF_LO_LSB +: LIDF_FIELD_W]; // RL4
              r_next.y = d[LIDF_HI_LSB +: LIDF_FIELD_W]; // RL4
            end
            3'h3: begin
              r_next.w = d[LIDF_LO_LSB +: LIDF_FIELD_W]; // RL4
              r_next.h = d[LIDF_HI_LSB +: LIDF_FIELD_W]; // RL4
            end
            3'h4: r_next.base = d[31:LIDF_BASE_LSB]; // RL3
            3'h5: begin
              r_next.hr = d[LIDF_LO_LSB +: LIDF_FIELD_W]; // RL4
              r_next.vr = d[LIDF_HI_LSB +: LIDF_FIELD_W]; // RL4
              r_next.mode = d[LIDF_MODE_LSB +: 2]; // RL1
              r_next.rem = r_reg.len - LIDF_FIX_LEN;
              r_next.hidx = 6'h0;
              r_next.st = LIDF_IMG;
            end
            default: ;
          endcase
        end
      end
      LIDF_IMG: begin
        // parameter checks run once, before any image byte is taken
        if (r_reg.hidx == 6'h0 && r_reg.widx != 3'h0) begin
          r_next.widx = 3'h0;
          if (r_reg.mode == LIDF_MODE_RSVD) e = LIDF_ERR_MODE; // RL1 RL9
          else if (r_reg.w == 12'h0 || r_reg.h == 12'h0 || r_reg.w > LIDF_MAX_W)
            e = LIDF_ERR_SIZE; // RL8
          else if (xw > {1'b0, r_reg.hr} || yh > {1'b0, r_reg.vr})
            e = LIDF_ERR_BOUNDS; // RL7
        end else if (avail) begin
          consume = 1'b1;
          if (cur_b != lidf_hdr_byte(r_reg.hidx, r_reg.h, r_reg.w)) begin
            if (cur_b == LIDF_MK_EOI && (r_reg.hidx == 6'd1 || r_reg.hidx == 6'd3 ||
                                         r_reg.hidx == 6'd22))
              e = LIDF_ERR_EOI; // RL15
            else
              e = LIDF_ERR_HDR; // RL10 RL11 RL12 RL22 RL23
          end else if (r_reg.hidx == LIDF_IMG_HDR_LEN - 6'h1) begin
            r_next.st = LIDF_DATA;
          end
          r_next.hidx = r_reg.hidx + 6'h1;
        end else if (dry) begin
          e = LIDF_ERR_SHORT; // RL13
        end
      end
      LIDF_DATA: begin
        if (dec_pix_valid_i && dec_pix_last_i) begin
          r_next.st = LIDF_TAIL;
          r_next.ff_fwd = 1'b0;
        end
        if (r_reg.ff_pend) begin
          if (avail && cur_b[7]) begin
            consume = 1'b1;
            r_next.ff_pend = 1'b0;
            if (cur_b == LIDF_MK_EOI) e = LIDF_ERR_EOI; // RL15
            else if (lidf_unsup(cur_b)) e = LIDF_ERR_HDR; // RL12
            else e = LIDF_ERR_EOI; // RL15
          end else if (dec_byte_valid_o && dec_byte_ready_i) begin
            r_next.ff_pend = 1'b0;
            r_next.ff_fwd = 1'b1;
          end else if (dry) begin
            e = LIDF_ERR_SHORT; // RL13
          end
        end else if (avail) begin
          if (cur_b == LIDF_MK_PREFIX && !r_reg.ff_fwd) begin
            consume = 1'b1;
            r_next.ff_pend = 1'b1;
          end else if (dec_byte_ready_i) begin
            consume = 1'b1;
            r_next.ff_fwd = 1'b0;
          end
        end else if (dry && !(dec_pix_valid_i && dec_pix_last_i)) begin
          e = LIDF_ERR_SHORT; // RL13
        end
      end
      LIDF_TAIL: begin
        if (avail) begin
          consume = 1'b1;
          if (!r_reg.ff_pend) begin
            if (cur_b == LIDF_MK_PREFIX) r_next.ff_pend = 1'b1;
            else e = LIDF_ERR_EOI; // RL15
          end else if (cur_b != LIDF_MK_EOI) begin
            e = LIDF_ERR_EOI; // RL15
          end else if (r_reg.rem != 32'h1 || dec_residue_i) begin
            e = LIDF_ERR_LONG; // RL14
          end else begin
            r_next.st = LIDF_DONE; // RL26
          end
        end else if (dry) begin
          e = LIDF_ERR_EOI; // RL15
        end
      end
      LIDF_DONE, LIDF_FAIL: ;
      default: r_next.st = LIDF_IDLE;
    endcase

    // byte taken: shift toward the low lane, drop pad bytes past the length
    if (consume) begin
      r_next.wbuf = {8'h0, r_reg.wbuf[31:8]}; // RL18
      r_next.rem = r_reg.rem - 32'h1;
      r_next.wcnt = (r_reg.rem == 32'h1) ? 3'h0 : r_reg.wcnt - 3'h1; // RL20
    end

    if (busy && dec_err_i && e == LIDF_ERR_NONE) e = LIDF_ERR_DPATH; // RL16
    if (busy && e != LIDF_ERR_NONE) begin
      r_next.st = LIDF_FAIL; // RL16
      r_next.err = e; // RL25
    end

    // pixels pass only while the image is live; 16bpp keeps top bits
    if (r_reg.st == LIDF_DATA && dec_pix_valid_i) begin
      r_next.pix_v = 1'b1;
      case (r_reg.mode)
        LIDF_MODE_16: r_next.pix = {8'h0, dec_pix_i[23:19], dec_pix_i[15:10],
                                    dec_pix_i[7:3]}; // RL2 RL19
        LIDF_MODE_16UP: r_next.pix = {dec_pix_i[23:19], 3'h0, dec_pix_i[15:10], 2'h0,
                                      dec_pix_i[7:3], 3'h0}; // RL2 RL19
        default: r_next.pix = dec_pix_i; // RL19
      endcase
    end

    if (!sel_i) r_next.st = LIDF_IDLE; // RL17
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r_reg <= '0;
      r_reg.st <= LIDF_IDLE;
      r_reg.en <= LIDF_CTRL_EN_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // source is stalled once the length is used up, so nothing past it is read
  assign src_ready_o = (r_reg.st == LIDF_CMD) ||
                       ((r_reg.st == LIDF_IMG || r_reg.st == LIDF_DATA ||
                         r_reg.st == LIDF_TAIL) && !avail && r_reg.rem != 32'h0); // RL13
  assign dec_byte_o = r_reg.ff_pend ? LIDF_MK_PREFIX : cur_b;
  assign dec_byte_valid_o = (r_reg.st == LIDF_DATA) &&
                            (r_reg.ff_pend ? (avail && !cur_b[7]) :
                             (avail && (cur_b != LIDF_MK_PREFIX || r_reg.ff_fwd))); // RL21
  assign done_o = (r_reg.st == LIDF_DONE); // RL26
  assign err_o = (r_reg.st == LIDF_FAIL); // RL16
  assign err_code_o = r_reg.err;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !r_reg.ack;
  assign avs_readdata_o = r_reg.rdata;
  assign avs_response_o = r_reg.resp;
  assign img_width_o = r_reg.w;
  assign img_height_o = r_reg.h;
  assign thr1_o = LIDF_THR1; // RL24
  assign thr2_o = LIDF_THR2; // RL24
  assign thr3_o = LIDF_THR3; // RL24
  assign reset_val_o = LIDF_RESET_VAL; // RL24
  assign pix_o = r_reg.pix;
  assign pix_valid_o = r_reg.pix_v;
  assign mode_o = r_reg.mode;
  assign hres_o = r_reg.hr;
  assign base_addr_o = {r_reg.base, 7'h0}; // RL3

endmodule // lidf_top

// ==== lidf_top_asserts.sv ====
// lidf_top_asserts: port checks on the decode front.
// assumes bind onto lidf_top, single clock, async low reset.
module lidf_top_chk (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic sel_i,
  input wire logic done_o,
  input wire logic err_o,
  input wire logic [3:0] err_code_o,
  input wire logic src_ready_o,
  input wire logic dec_pix_valid_i,
  input wire logic [23:0] pix_o,
  input wire logic pix_valid_o,
  input wire logic [1:0] mode_o,
  input wire logic [31:0] base_addr_o,
  input wire logic [7:0] thr1_o,
  input wire logic [7:0] thr2_o,
  input wire logic [7:0] thr3_o,
  input wire logic [7:0] reset_val_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_excl; !(done_o && err_o); endproperty
  a_excl: assert property (p_excl) else $error("done and fail together");
  property p_done; done_o && sel_i |=> done_o; endproperty
  a_done: assert property (p_done) else $error("done dropped while selected");
  property p_err; err_o && sel_i |=> err_o && $stable(err_code_o); endproperty
  a_err: assert property (p_err) else $error("fail code changed");
  property p_desel; !sel_i |=> !done_o && !err_o; endproperty
  a_desel: assert property (p_desel) else $error("not idle after deselect");
  property p_code; err_o |-> err_code_o inside {[4'h1:4'h9]}; endproperty
  a_code: assert property (p_code) else $error("fail without code");
  property p_ready; src_ready_o |-> $past(sel_i); endproperty
  a_ready: assert property (p_ready) else $error("word taken when not selected");
  property p_pix; pix_valid_o |-> $past(dec_pix_valid_i); endproperty
  a_pix: assert property (p_pix) else $error("pixel without decoder pixel");
  // up-converting 16bpp lanes carry zero low bits
  property p_pad;
    pix_valid_o && mode_o == 2'h3 |-> pix_o[18:16] == 3'h0 && pix_o[9:8] == 2'h0
      && pix_o[2:0] == 3'h0;
  endproperty
  a_pad: assert property (p_pad) else $error("up-convert lanes not padded");
  property p_base; base_addr_o[6:0] == 7'h00; endproperty
  a_base: assert property (p_base) else $error("base low bits not ignored");
  property p_thr;
    thr1_o == 8'h03 && thr2_o == 8'h07 && thr3_o == 8'h15 && reset_val_o == 8'h40;
  endproperty
  a_thr: assert property (p_thr) else $error("fixed parameters wrong");
  c_done: cover property ($rose(done_o));
  c_err: cover property (err_o && err_code_o == 4'h8);
  c_pix: cover property (pix_valid_o);
endmodule // lidf_top_chk
bind lidf_top lidf_top_chk i_lidf_top_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .sel_i(sel_i),
  .done_o(done_o), .err_o(err_o), .err_code_o(err_code_o), .src_ready_o(src_ready_o),
  .dec_pix_valid_i(dec_pix_valid_i), .pix_o(pix_o), .pix_valid_o(pix_valid_o), .mode_o(mode_o),
  .base_addr_o(base_addr_o), .thr1_o(thr1_o), .thr2_o(thr2_o), .thr3_o(thr3_o),
  .reset_val_o(reset_val_o));

// ==== lidf_top_tb.sv ====
// lidf_top_tb: register, command and stream tests of the decode front.
// assumes lidf_src_model feeds words; the bench plays parser and decoder.
module lidf_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lidf_pkg::*;
  logic clk_i, arst_n_i, rd, wr, wa, sel, rdy, pv, pl, res, sv, sr, bv, dn, er, pvo, de;
  logic [5:0] adr, nw, hold;
  logic [31:0] wd, rdo, rdat, sd, bao, len;
  logic [1:0] resp, rspo, md, mdo;
  logic [3:0] code;
  logic [23:0] po;
  logic [23:0] pin = 24'hd6b59c;
  logic [11:0] hro, wo, ho, x, w;
  logic [7:0] bo;
  logic [31:0] mem [32];
  logic [31:0] base = 32'h123456f5;
  logic [7:0] img [$];
  logic [7:0] hdr [35] = '{8'hff, 8'hd8, 8'hff, 8'hf7, 8'h00, 8'h11, 8'h08, 8'h00, 8'h01,
    8'h00, 8'h01, 8'h03, 8'h01, 8'h11, 8'h00, 8'h02, 8'h11, 8'h00, 8'h03, 8'h11, 8'h00,
    8'hff, 8'hda, 8'h00, 8'h0c, 8'h03, 8'h01, 8'h00, 8'h02, 8'h00, 8'h03, 8'h00, 8'h00,
    8'h02, 8'h00};
  logic [3:0] sexp [11] = '{4'h0, 4'h0, 4'h0, 4'h8, 4'h8, 4'h8, 4'h7, 4'h2, 4'h3, 4'h3, 4'h0};
  logic [3:0] hexp [7] = '{4'h1, 4'h4, 4'h5, 4'h5, 4'h6, 4'h6, 4'h9};
  int n_errors = 0;
  int tests_run = 0;
  int nb, got;
  lidf_top i_lidf_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdo), .avs_response_o(rspo), .avs_waitrequest_o(wa), .sel_i(sel),
    .done_o(dn), .err_o(er), .err_code_o(code), .src_data_i(sd), .src_valid_i(sv),
    .src_ready_o(sr), .dec_byte_o(bo), .dec_byte_valid_o(bv), .dec_byte_ready_i(rdy),
    .dec_pix_valid_i(pv), .dec_pix_i(pin), .dec_pix_last_i(pl), .dec_residue_i(res),
    .dec_err_i(de), .img_width_o(wo), .img_height_o(ho), .thr1_o(), .thr2_o(), .thr3_o(),
    .reset_val_o(), .pix_o(po), .pix_valid_o(pvo), .mode_o(mdo), .hres_o(hro),
    .base_addr_o(bao));
  lidf_src_model i_lidf_src_model (.clk_i(clk_i), .arst_n_i(arst_n_i), .start_i(!sel),
    .mem_i(mem), .n_i(nw), .hold_i(hold), .ready_i(sr), .data_o(sd), .valid_o(sv));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    rd <= !we;
    wr <= we;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (wa !== 1'b0);
    rdat = rdo;
    resp = rspo;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  function automatic logic [23:0] ex_pix(input logic [1:0] m, input logic [23:0] p);
    case (m)
      2'h1: return {8'h00, p[23:19], p[15:10], p[7:3]};
      2'h3: return {p[23:19], 3'h0, p[15:10], 2'h0, p[7:3], 3'h0};
      default: return p;
    endcase
  endfunction
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one command; v picks the stream, len 0 means exact length
  task automatic go(input int v);
    img = {};
    foreach (hdr[i]) img.push_back(hdr[i]);
    if (v == 3) img[6] = 8'h07;
    if (v == 4) img[10] = 8'h02;
    if (v == 5) img = {img, 8'hff, 8'hfe, 8'hff, 8'hd9};
    else if (v == 6) img = {img, 8'hff, 8'hd9};
    else if (v == 7) img.push_back(8'h00);
    else img = {img, 8'h00, 8'hff, 8'hd9};
    if (v == 8) img.push_back(8'h00);
    for (int i = 0; i < 32; i++) mem[i] = 32'hffffffff;
    mem[1] = (len != 0) ? len : 32'h10 + img.size();
    mem[2] = {16'h0002, 4'hf, x};
    mem[3] = {16'h0001, 4'hf, w};
    mem[4] = base;
    mem[5] = {16'h0008, md, 2'h3, 12'h010};
    foreach (img[i]) mem[6 + i / 4][8 * (i % 4) +: 8] = img[i];
    nw <= 6'(6 + (img.size() + 3) / 4);
    hold <= (v < 3 || v > 7) ? 6'd15 : 6'h3f;
    res <= (v == 9);
    nb = 0;
    got = 0;
    @(posedge clk_i) sel <= 1'b1;
    for (int k = 0; k < 3000 && dn !== 1'b1 && er !== 1'b1; k++) begin
      @(posedge clk_i);
      pv <= 1'b0;
      pl <= 1'b0;
      if (bv === 1'b1 && rdy) begin
        nb++;
        chk({24'h0, bo}, 32'h0);
      end
      if (pvo === 1'b1) begin
        got++;
        chk({8'h0, po}, {8'h0, ex_pix(md, pin)});
      end
      if (nb == 1 && hold == 6'd15) begin
        if (v == 10) break;
        pv <= 1'b1;
        pl <= 1'b1;
        hold <= 6'h3f;
      end
    end
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    #(50 * 60000);
    n_errors++;
    test_done();
  end
  initial begin
    arst_n_i = 1'b0;
    {rd, wr, sel, pv, pl, res, de} = '0;
    {adr, wd, len, nw, hold} = '0;
    rdy = 1'b1;
    x = 12'h003;
    w = 12'h001;
    md = 2'h1;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    bus(1'b0, LIDF_OFS_CTRL, 32'h0);
    chk(rdat, 32'h1);
    bus(1'b0, 6'h3c, 32'h0);
    chk({30'h0, resp}, {30'h0, LIDF_RESP_SLVERR});
    chk(rdat, 32'h0);
    bus(1'b1, LIDF_OFS_CTRL, 32'h0);
    @(posedge clk_i) sel <= 1'b1;
    bus(1'b0, LIDF_OFS_STATUS, 32'h0);
    chk(rdat, 32'h0);
    @(posedge clk_i) sel <= 1'b0;
    bus(1'b1, LIDF_OFS_CTRL, 32'h1);
    for (int c = 0; c < 7; c++) begin
      x = 12'h003;
      w = (c == 2) ? 12'h000 : (c == 3) ? 12'h801 : (c == 5) ? 12'h800 : 12'h001;
      md = (c == 1) ? 2'h0 : 2'h1;
      len = (c == 0) ? 32'h10 : 32'h0;
      x = (c == 4) ? 12'h010 : x;
      de <= (c == 6);
      go(11);
      chk({26'h0, dn, er, code}, {26'h0, 2'b01, hexp[c]});
      @(posedge clk_i) sel <= 1'b0;
      @(posedge clk_i);
    end
    len = 32'h0;
    de <= 1'b0;
    w = 12'h001;
    for (int v = 0; v < 11; v++) begin
      md = (v < 3) ? 2'(v + 1) : 2'h1;
      x = (v == 1) ? 12'h00f : 12'h003;
      go(v);
      if (v == 10) begin
        @(posedge clk_i) sel <= 1'b0;
        repeat (2) @(posedge clk_i);
        bus(1'b0, LIDF_OFS_STATUS, 32'h0);
        chk({27'h0, dn, er, rdat[10:8]}, 32'h0);
      end else begin
        chk({26'h0, dn, er, code},
            {26'h0, sexp[v] == 4'h0, sexp[v] != 4'h0, sexp[v]});
        if (sexp[v] == 4'h0) chk(got, 1);
      end
      if (v == 0) begin
        chk(bao, {base[31:7], 7'h00});
        chk({8'h0, ho, wo}, {8'h0, 12'h001, 12'h001});
        chk({18'h0, hro, mdo}, {18'h0, 12'h010, 2'h1});
        bus(1'b0, LIDF_OFS_POS, 32'h0);
        chk(rdat, {16'h0002, 16'h0003});
        bus(1'b0, LIDF_OFS_REMAIN, 32'h0);
        chk(rdat, 32'h0);
      end
      @(posedge clk_i) sel <= 1'b0;
      @(posedge clk_i);
    end
    test_done();
  end
endmodule // lidf_top_tb
